// file: logic/pwm_wave_counter.v
// Shared-counter wave generator with four compare channels
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pwm_wave_counter_defs.vh"

module pwm_wave_counter
(
    input wire core_clk,
    input wire reset_n,
    input wire [`PWC_ADDR_W-1:0] reg_addr,
    input wire [`PWC_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`PWC_DATA_W-1:0] reg_rdata,
    input wire load_a,
    input wire sequence_start_task,
    input wire stop_task,
    input wire cmp_load,
    input wire [`PWC_PAR_W-1:0] cmp_data0,
    input wire [`PWC_PAR_W-1:0] cmp_data1,
    input wire [`PWC_PAR_W-1:0] cmp_data2,
    input wire [`PWC_PAR_W-1:0] cmp_data3,
    output reg cmp_load_ready,
    output reg period_end,
    output reg running,
    output reg [`PWC_CHANNELS-1:0] pwm_out
);

    // Software registers
    reg count_up_down;
    reg [`PWC_CNT_W-1:0] counter_top_value;
    reg [`PWC_PRE_W-1:0] prescale;

    // Active period state
    reg [`PWC_CNT_W-1:0] cnt;
    reg down;
    reg mode_act;
    reg [`PWC_CNT_W-1:0] top_act;
    reg [`PWC_CNT_W-1:0] cmp_act [0:`PWC_CHANNELS-1];
    reg [`PWC_CHANNELS-1:0] pol_act;
    reg stop_pend;

    // Loaded values waiting for the period boundary
    reg [`PWC_CNT_W-1:0] cmp_pend [0:`PWC_CHANNELS-1];
    reg [`PWC_CHANNELS-1:0] pol_pend;
    reg [`PWC_CNT_W-1:0] top_pend;
    reg pend;

    reg [`PWC_DIV_W-1:0] div_cnt;

    wire tick;
    wire wrap;
    wire boundary;
    wire [`PWC_PAR_W-1:0] par [0:`PWC_CHANNELS-1];
    reg [`PWC_CNT_W-1:0] next_cnt;
    reg next_down;
    reg [`PWC_CHANNELS-1:0] next_out;
    integer i;
    integer j;
    integer k;

    assign par[0] = cmp_data0;
    assign par[1] = cmp_data1;
    assign par[2] = cmp_data2;
    assign par[3] = cmp_data3;

    // Divide-by-2^p mask for the tick clock
    function [`PWC_DIV_W-1:0] pre_mask;
        input [`PWC_PRE_W-1:0] p;
        reg [`PWC_DIV_W:0] one_hot;
        begin
            one_hot = {{`PWC_DIV_W{1'b0}}, 1'b1} << p;
            pre_mask = one_hot[`PWC_DIV_W-1:0] - {{(`PWC_DIV_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // Falling-edge level is high while the count is below compare
    function wave_level;
        input [`PWC_CNT_W-1:0] count;
        input [`PWC_CNT_W-1:0] cmp;
        input pol_falling;
        reg falling_level;
        begin
            falling_level = (count < cmp);
            wave_level = pol_falling ? falling_level : ~falling_level;
        end
    endfunction

    assign tick = running && ((div_cnt & pre_mask(prescale)) == pre_mask(prescale));

    // Counter next value and direction
    always @*
    begin
        next_cnt = cnt;
        next_down = down;
        if (mode_act == 1'b0)
        begin
            if ({1'b0, cnt} + 16'h0001 >= {1'b0, top_act})
            begin
                next_cnt = `PWC_CNT_ZERO;
            end
            else
            begin
                next_cnt = cnt + `PWC_CNT_ONE;
            end
            next_down = 1'b0;
        end
        else if (down == 1'b0)
        begin
            if ({1'b0, cnt} + 16'h0001 >= {1'b0, top_act})
            begin
                next_cnt = top_act;
                next_down = (top_act != `PWC_CNT_ZERO);
            end
            else
            begin
                next_cnt = cnt + `PWC_CNT_ONE;
            end
        end
        else
        begin
            if (cnt <= `PWC_CNT_ONE)
            begin
                next_cnt = `PWC_CNT_ZERO;
                next_down = 1'b0;
            end
            else
            begin
                next_cnt = cnt - `PWC_CNT_ONE;
            end
        end
    end

    // Period ends when the count returns to zero
    assign wrap = tick && (next_cnt == `PWC_CNT_ZERO) && !next_down &&
        (mode_act == 1'b0 || down == 1'b1 || top_act == `PWC_CNT_ZERO);
    assign boundary = wrap;

    // All channels compare one counter so they share edge alignment
    always @*
    begin
        next_out = pwm_out;
        for (i = 0; i < `PWC_CHANNELS; i = i + 1)
        begin
            next_out[i] = wave_level(next_cnt, cmp_act[i], pol_act[i]);
        end
    end

    // Register writes; the top register only feeds sampling points
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_up_down <= 1'b0;
            counter_top_value <= `PWC_RST_TOP;
            prescale <= `PWC_RST_PRE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `PWC_OFF_MODE:
                    count_up_down <= reg_wdata[`PWC_MODE_UPDOWN_BIT];
                `PWC_OFF_TOP:
                    counter_top_value <= reg_wdata[`PWC_CNT_W-1:0];
                `PWC_OFF_PRESCALE:
                    prescale <= reg_wdata[`PWC_PRE_W-1:0];
                default:
                    count_up_down <= count_up_down;
            endcase
        end
    end

    // Register reads, data one cycle after the strobe; compares unreadable
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= {`PWC_DATA_W{1'b0}};
        end
        else if (reg_rd)
        begin
            reg_rdata <= {`PWC_DATA_W{1'b0}};
            case (reg_addr)
                `PWC_OFF_MODE:
                    reg_rdata[`PWC_MODE_UPDOWN_BIT] <= count_up_down;
                `PWC_OFF_TOP:
                    reg_rdata[`PWC_CNT_W-1:0] <= counter_top_value;
                `PWC_OFF_PRESCALE:
                    reg_rdata[`PWC_PRE_W-1:0] <= prescale;
                `PWC_OFF_STATUS:
                begin
                    reg_rdata[`PWC_STAT_RUN_BIT] <= running;
                    reg_rdata[`PWC_STAT_DOWN_BIT] <= down;
                    reg_rdata[`PWC_STAT_PEND_BIT] <= pend;
                end
                `PWC_OFF_COUNT:
                    reg_rdata[`PWC_CNT_W-1:0] <= cnt;
                default:
                    reg_rdata <= {`PWC_DATA_W{1'b0}};
            endcase
        end
        else
        begin
            reg_rdata <= {`PWC_DATA_W{1'b0}};
        end
    end

    // Decoder loads: held until the period boundary so edges never glitch
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend <= 1'b0;
            pol_pend <= {`PWC_CHANNELS{1'b0}};
            top_pend <= `PWC_RST_TOP;
            for (j = 0; j < `PWC_CHANNELS; j = j + 1)
            begin
                cmp_pend[j] <= `PWC_CNT_ZERO;
            end
        end
        else if (cmp_load && cmp_load_ready)
        begin
            pend <= 1'b1;
            for (j = 0; j < `PWC_CHANNELS; j = j + 1)
            begin
                cmp_pend[j] <= par[j][`PWC_CNT_W-1:0];
                pol_pend[j] <= par[j][`PWC_POL_BIT];
            end
            if (load_a)
            begin
                cmp_pend[`PWC_CHANNELS-1] <= `PWC_CNT_ZERO;
                top_pend <= cmp_data3[`PWC_CNT_W-1:0];
            end
            else
            begin
                top_pend <= counter_top_value;
            end
        end
        else if (sequence_start_task || boundary)
        begin
            pend <= 1'b0;
        end
    end

    // Only one group may wait; the decoder stalls on this
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmp_load_ready <= 1'b1;
        end
        else
        begin
            // A group taken on a start or wrap edge still waits, so ready stays low
            cmp_load_ready <= !(cmp_load && cmp_load_ready) &&
                (!pend || sequence_start_task || boundary);
        end
    end

    // Run control, counter and period parameters
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            running <= 1'b0;
            stop_pend <= 1'b0;
            cnt <= `PWC_CNT_ZERO;
            down <= 1'b0;
            mode_act <= 1'b0;
            top_act <= `PWC_RST_TOP;
            pol_act <= {`PWC_CHANNELS{1'b0}};
            div_cnt <= {`PWC_DIV_W{1'b0}};
            period_end <= 1'b0;
            for (k = 0; k < `PWC_CHANNELS; k = k + 1)
            begin
                cmp_act[k] <= `PWC_CNT_ZERO;
            end
        end
        else
        begin
            period_end <= boundary;
            if (sequence_start_task)
            begin
                running <= 1'b1;
                stop_pend <= 1'b0;
                cnt <= `PWC_CNT_ZERO;
                down <= 1'b0;
                div_cnt <= {`PWC_DIV_W{1'b0}};
                mode_act <= count_up_down;
                top_act <= pend ? top_pend : (load_a ? top_act : counter_top_value);
                if (pend)
                begin
                    pol_act <= pol_pend;
                    for (k = 0; k < `PWC_CHANNELS; k = k + 1)
                    begin
                        cmp_act[k] <= cmp_pend[k];
                    end
                end
            end
            else if (running)
            begin
                div_cnt <= div_cnt + {{(`PWC_DIV_W-1){1'b0}}, 1'b1};
                if (stop_task)
                begin
                    stop_pend <= 1'b1;
                end
                if (tick)
                begin
                    cnt <= next_cnt;
                    down <= next_down;
                end
                if (boundary)
                begin
                    mode_act <= count_up_down;
                    if (stop_pend || stop_task)
                    begin
                        running <= 1'b0;
                    end
                    if (pend)
                    begin
                        top_act <= top_pend;
                        pol_act <= pol_pend;
                        for (k = 0; k < `PWC_CHANNELS; k = k + 1)
                        begin
                            cmp_act[k] <= cmp_pend[k];
                        end
                    end
                end
            end
        end
    end

    // Outputs change only on ticks; steady when stopped
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwm_out <= {`PWC_CHANNELS{1'b0}};
        end
        else if (tick)
        begin
            pwm_out <= next_out;
        end
    end

endmodule

// file: logic/pwm_wave_counter_defs.vh
// Constants shared by the wave counter core and its tests
// Overview of operation
// - One shared 15-bit counter, four compare channels
// - Software mode bit selects up or up-down
// - Top value sets turning point and period
// - Top below compare: no edges, output steady
// - Compares load only through decoder port
// - Top register writable anytime without glitches
// - Load_a load takes top from memory
// - Otherwise top sampled at start and loads
// - Up mode wraps to zero at top
// - Compare zero low, compare top high in up mode only
// - Up mode pulses edge aligned
// - Up period is top ticks
// - Up-down reverses at top, center aligned
// - Up-down period is twice top ticks
// - Polarity comes from loaded memory value
// - Bit 15 polarity, bits 14:0 compare
// - Load_a groups: three compares, then top
`ifndef PWM_WAVE_COUNTER_DEFS_VH
`define PWM_WAVE_COUNTER_DEFS_VH

`define PWC_ADDR_W 8
`define PWC_DATA_W 32
`define PWC_CNT_W 15
`define PWC_PAR_W 16
`define PWC_POL_BIT 15
`define PWC_CHANNELS 4
`define PWC_PRE_W 3
`define PWC_DIV_W 7

`define PWC_OFF_MODE 8'h00
`define PWC_OFF_TOP 8'h04
`define PWC_OFF_PRESCALE 8'h08
`define PWC_OFF_STATUS 8'h0C
`define PWC_OFF_COUNT 8'h10

`define PWC_MODE_UPDOWN_BIT 0
`define PWC_STAT_RUN_BIT 0
`define PWC_STAT_DOWN_BIT 1
`define PWC_STAT_PEND_BIT 2

`define PWC_RST_TOP 15'h03E8
`define PWC_RST_PRE 3'h0
`define PWC_CNT_ZERO 15'h0000
`define PWC_CNT_ONE 15'h0001

`endif

// file: test/led_load.sv
// Pin load model: counts high cycles on each output
`timescale 1ns/1ps
module led_load
(
    input wire core_clk,
    input wire reset_n,
    input wire clear,
    input wire [3:0] pins,
    output logic [63:0] on_counts
);
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n || clear)
            on_counts <= 64'h0;
        else
            for (int i = 0; i < 4; i++)
                on_counts[16*i +: 16] <= on_counts[16*i +: 16] + 16'(pins[i]);
    end
endmodule

// file: test/pwm_wave_counter_monitor.sv
// Port-level assertions for the wave counter
`timescale 1ns/1ps
`include "pwm_wave_counter_defs.vh"
module pwm_wave_counter_monitor
(
    input wire core_clk,
    input wire reset_n,
    input wire [`PWC_ADDR_W-1:0] reg_addr,
    input wire reg_rd,
    input wire [`PWC_DATA_W-1:0] reg_rdata,
    input wire sequence_start_task,
    input wire cmp_load,
    input wire cmp_load_ready,
    input wire period_end,
    input wire running,
    input wire [`PWC_CHANNELS-1:0] pwm_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_idle_hold; !running && !$past(running) |-> $stable(pwm_out); endproperty
    property p_ready_drop; cmp_load && cmp_load_ready |=> !cmp_load_ready; endproperty
    property p_start; sequence_start_task && !running |=> running; endproperty
    property p_pe_pulse; period_end |=> !period_end; endproperty
    property p_stop_wrap; $fell(running) |-> ##[0:2] period_end; endproperty
    property p_rd_gap; reg_rdata != 32'h0 |-> $past(reg_rd); endproperty
    property p_stat_run; reg_rd && reg_addr == 8'h0C |=> reg_rdata[0] == $past(running);
    endproperty
    property p_stat_bits; reg_rd && reg_addr == 8'h0C |=> reg_rdata[31:3] == 29'h0; endproperty
    property p_count_w; reg_rd && reg_addr == 8'h10 |=> reg_rdata[31:15] == 17'h0; endproperty
    // Pending group waits for a start while idle
    property p_ready_hold;
        !cmp_load_ready && !running && !sequence_start_task |=> !cmp_load_ready;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("outputs moved while idle");
    a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high");
    a_start: assert property (p_start) else $error("start ignored");
    a_pe_pulse: assert property (p_pe_pulse) else $error("period end too long");
    a_stop_wrap: assert property (p_stop_wrap) else $error("stop off period edge");
    a_rd_gap: assert property (p_rd_gap) else $error("read data out of slot");
    a_stat_run: assert property (p_stat_run) else $error("status run bit wrong");
    a_stat_bits: assert property (p_stat_bits) else $error("status upper bits set");
    a_count_w: assert property (p_count_w) else $error("count wider than 15");
    a_ready_hold: assert property (p_ready_hold) else $error("group applied idle");
    c_load: cover property (cmp_load && cmp_load_ready);
    c_wrap: cover property (period_end);
    c_stop: cover property ($fell(running));
endmodule
bind pwm_wave_counter pwm_wave_counter_monitor i_pwm_wave_counter_monitor(.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sequence_start_task(sequence_start_task), .cmp_load(cmp_load),
    .cmp_load_ready(cmp_load_ready), .period_end(period_end), .running(running),
    .pwm_out(pwm_out));

// file: test/pwm_wave_counter_test.sv
// Directed tests of the wave counter through its ports
`timescale 1ns/1ps
`include "pwm_wave_counter_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module pwm_wave_counter_test;
    logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, load_a = 0, clear = 0;
    logic sequence_start_task = 0, stop_task = 0, cmp_load = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [15:0] cd0 = 16'h0, cd1 = 16'h0, cd2 = 16'h0, cd3 = 16'h0;
    logic cmp_load_ready, period_end, running;
    logic [3:0] pwm_out, held;
    logic [63:0] on_counts;
    int fail_count = 0, num_checks = 0, pe_n;
    pwm_wave_counter i_pwm_wave_counter(.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .load_a(load_a), .sequence_start_task(sequence_start_task),
        .stop_task(stop_task), .cmp_load(cmp_load), .cmp_data0(cd0), .cmp_data1(cd1),
        .cmp_data2(cd2), .cmp_data3(cd3), .cmp_load_ready(cmp_load_ready),
        .period_end(period_end), .running(running), .pwm_out(pwm_out));
    led_load i_led_load(.core_clk(core_clk), .reset_n(reset_n), .clear(clear),
        .pins(pwm_out), .on_counts(on_counts));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task wr(input [7:0] a, input [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // 0: period end, 1: load ready, 2: stopped
    task wait_hi(input int s);
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge core_clk);
            #1;
            if ((s == 0 ? period_end : s == 1 ? cmp_load_ready : !running) === 1'b1)
                return;
        end
        fail_count++;
        $display("CHECK FAILED wait %0d exp 1 got 0", s);
    endtask
    task ld(input [15:0] a, input [15:0] b, input [15:0] c, input [15:0] e);
        wait_hi(1);
        @(posedge core_clk);
        cmp_load <= 1;
        {cd0, cd1, cd2, cd3} <= {a, b, c, e};
        @(posedge core_clk);
        cmp_load <= 0;
    endtask
    // Count n whole cycles so the window phase cannot skew the totals
    task meas(input int n);
        @(posedge core_clk);
        clear <= 1;
        @(posedge core_clk);
        clear <= 0;
        pe_n = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            #1 pe_n += period_end;
        end
    endtask
    task chk(input int ch, input [15:0] e);
        `CHK("on_count", e, on_counts[16*ch +: 16])
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        stop_test;
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        rd(8'h04);
        `CHK("top", 32'h3E8, d)
        `CHK("ready", 1'b1, cmp_load_ready)
        rd(8'h20);
        `CHK("unmapped", 32'h0, d)
        wr(8'h04, 32'd10);
        rd(8'h04);
        `CHK("top", 32'd10, d)
        ld(16'h8000, 16'h800A, 16'h8004, 16'h0004);
        @(posedge core_clk) sequence_start_task <= 1;
        @(posedge core_clk) sequence_start_task <= 0;
        wait_hi(0);
        wait_hi(0);
        meas(30);
        `CHK("periods", 3, pe_n)
        chk(0, 0);
        chk(1, 30);
        chk(2, 12);
        chk(3, 18);
        $display("up mode test done");
        wr(8'h00, 32'h1);
        wait_hi(0);
        wait_hi(0);
        meas(40);
        `CHK("periods", 2, pe_n)
        chk(2, 14);
        chk(3, 26);
        $display("up-down test done");
        wr(8'h04, 32'd6);
        ld(16'h8000, 16'h8003, 16'h800C, 16'h000C);
        wait_hi(1);
        wait_hi(0);
        meas(24);
        `CHK("periods", 2, pe_n)
        chk(1, 10);
        chk(2, 24);
        chk(3, 0);
        $display("reload test done");
        wr(8'h00, 32'h0);
        @(posedge core_clk) load_a <= 1;
        ld(16'h8002, 16'h8005, 16'h0002, 16'h0008);
        wait_hi(1);
        wait_hi(0);
        meas(16);
        `CHK("periods", 2, pe_n)
        chk(0, 4);
        chk(1, 10);
        chk(2, 12);
        $display("load_a test done");
        wr(8'h08, 32'h1);
        wait_hi(0);
        wait_hi(0);
        meas(32);
        `CHK("periods", 2, pe_n)
        chk(0, 8);
        chk(1, 20);
        chk(2, 24);
        $display("prescale test done");
        @(posedge core_clk) stop_task <= 1;
        @(posedge core_clk) stop_task <= 0;
        wait_hi(2);
        rd(8'h0C);
        `CHK("status", 1'b0, d[0])
        rd(8'h10);
        `CHK("count", 32'h0, d)
        held = pwm_out;
        meas(20);
        `CHK("periods", 0, pe_n)
        `CHK("hold", held, pwm_out)
        $display("stop test done");
        stop_test;
    end
endmodule
